// >>> shared/sfp_pkg.sv
// Constants for the status flag and prescaler register bank.
// Assumes a single core clock; the core drives register access and events.
package sfp_pkg;
   localparam logic [7:0] SFP_STATUS_ADDR = 8'h03;
   localparam logic [7:0] SFP_OPTION_ADDR = 8'h07;
   localparam logic [7:0] SFP_TIMER_ZERO_ADDR = 8'h01;
   localparam logic [7:0] SFP_OPTION_RESET = 8'h7B;
   // Status field positions
   localparam int SFP_ST_CARRY = 0;
   localparam int SFP_ST_DIGIT = 1;
   localparam int SFP_ST_ZERO = 2;
   localparam int SFP_ST_PD = 3;
   localparam int SFP_ST_TO = 4;
   // Option field positions
   localparam int SFP_OP_PS_LO = 0;
   localparam int SFP_OP_OWNER = 3;
   localparam int SFP_OP_EDGE = 4;
   localparam int SFP_OP_SRC = 5;
   localparam int SFP_OP_ASYNC = 6;
   localparam int SFP_OP_XTAL = 7;
   localparam int SFP_PRESCALE_WIDTH = 8;
   // Selected timer clock sources
   typedef enum logic [1:0] {
      SFP_SRC_INSTR = 2'h0,
      SFP_SRC_PIN = 2'h1,
      SFP_SRC_XTAL = 2'h2
   } sfp_src_e;
endpackage : sfp_pkg

// >>> src/sfp_edge_detect.sv
// Edge detector for the timer external input, with optional synchroniser.
// Assumes the pin level is otherwise synchronous to core_clk_i.
module sfp_edge_detect
   import sfp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic level_i,
   input wire logic sync_bypass_i,
   input wire logic falling_i,
   output logic edge_o
);
   logic sync_a;
   logic sync_b;
   logic prev;
   logic sel;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= level_i;
         sync_b <= sync_a;
      end
   end

   // Async mode skips the two-stage delay, trading metastability margin for latency
   assign sel = sync_bypass_i ? level_i : sync_b;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev <= 1'b0;
      end else begin
         prev <= sel;
      end
   end

   assign edge_o = falling_i ? (prev & ~sel) : (~prev & sel);
endmodule : sfp_edge_detect

// >>> src/sfp_prescaler.sv
// Shared 8-bit prescaler counter with ratio tap selection.
// Assumes tick_i is a one-cycle pulse from the owning clock source.
module sfp_prescaler
   import sfp_pkg::*;
#(
   parameter int WIDTH = SFP_PRESCALE_WIDTH
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic clear_i,
   input wire logic [2:0] ratio_i,
   input wire logic watchdog_mode_i,
   output logic [WIDTH-1:0] count_o,
   output logic out_tick_o
);
   logic [WIDTH-1:0] count;
   logic [3:0] shift;
   logic [WIDTH-1:0] mask;

   if (WIDTH != 8) begin : g_bad_width
      $error("sfp_prescaler supports only WIDTH of 8");
   end

   // Timer divides by 2^(code+1), watchdog by 2^code
   assign shift = watchdog_mode_i ? {1'b0, ratio_i} : ({1'b0, ratio_i} + 4'h1);
   assign mask = WIDTH'((9'h001 << shift) - 9'h001);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
      end else if (clear_i) begin
         count <= '0;
      end else if (tick_i) begin
         count <= count + 8'h01;
      end
   end

   // Ratio changes act on the next tick since mask is combinational
   assign out_tick_o = tick_i && !clear_i && ((count & mask) == mask);
   assign count_o = count;
endmodule : sfp_prescaler

// >>> src/sfp_status_option.sv
// Status flag register and timer/watchdog option register with shared prescaler.
// Assumes the core presents one register access and ALU result per cycle,
// and that watchdog and timer counters sit outside, fed by the ticks here.
// Summary of operation
// (RULE_01) Expiry flag set on power-up, kick or sleep; cleared on watchdog timeout.
// (RULE_02) Power-down flag set on power-up or kick; cleared by sleep.
// (RULE_03) Zero flag follows whether the ALU result is zero.
// (RULE_04) Digit flag records carry or borrow out of the low nibble.
// (RULE_05) Carry flag records carry or borrow out of the top bit.
// (RULE_06) Register writes change only the ALU flags, never the reset-cause pair.
// (RULE_07) Clearing status zeroes ALU flags then sets zero flag; cause flags kept.
// (RULE_08) Hibernation acts like sleep; overflow clears expiry only. Hibernation here does not assert watchdog_clear_o, sleep does.
// (RULE_09) Cause pair after reset: 00 sleep wake, 01 running overflow, 11 power-up.
// (RULE_10) Option bit 7 enables crystal; bit 5 picks instruction or external clock.
// (RULE_11) Option bit 6 zero synchronises external clock, one runs it asynchronously.
// (RULE_12) Option bit 4 selects rising or falling edge of the external input.
// (RULE_13) Option bit 3 gives prescaler to timer when zero, watchdog when one.
// (RULE_14) Ratio code divides timer by 2^(code+1), watchdog by 2^code.
// (RULE_15) One physical 8-bit prescaler, serving timer or watchdog, never both.
// (RULE_16) Kick clears prescaler and watchdog counter while watchdog owns prescaler.
// (RULE_17) Any timer register write clears prescaler while timer owns it.
// (RULE_18) Software moves prescaler to watchdog: clear timer, kick, max ratio, ratio.
// (RULE_19) Software moves prescaler to timer: kick first, then write option.
// (RULE_20) Timer counts undivided while the watchdog owns the prescaler.
// (RULE_21) Watchdog counts undivided base ticks while the timer owns the prescaler.
// (RULE_22) Ownership and ratio changes apply from the next prescaler tick.
module sfp_status_option
   import sfp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Power-up versus other reset cause, sampled on every edge in reset and on the first edge after release
   input wire logic power_on_reset_i,
   // Register access port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_write_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // ALU flag update
   input wire logic alu_update_i,
   input wire logic [7:0] alu_result_i,
   input wire logic alu_digit_carry_i,
   input wire logic alu_carry_i,
   // Core events, one-cycle pulses
   input wire logic watchdog_kick_i,
   input wire logic sleep_i,
   input wire logic hibernate_i,
   input wire logic watchdog_timeout_i,
   // Clock sources
   input wire logic instr_tick_i,
   input wire logic watchdog_base_tick_i,
   input wire logic timer_ext_input_i,
   input wire logic xtal_tick_i,
   // Outputs to timer zero and watchdog
   output logic crystal_enable_o,
   output logic timer_zero_tick_o,
   output logic watchdog_tick_o,
   output logic watchdog_clear_o,
   output logic [7:0] status_o,
   output logic [7:0] option_o
);
   logic watchdog_expiry_flag;
   logic power_down_flag;
   logic result_null_flag;
   logic low_nibble_overflow;
   logic msb_overflow_flag;
   logic [7:0] option;
   logic cause_pending;
   logic status_write;
   logic option_write;
   logic timer_zero_write;
   logic ext_edge;
   logic timer_src_tick;
   logic presc_in_tick;
   logic presc_out_tick;
   logic presc_clear;
   logic owner_is_wdt;
   logic [7:0] read_mux;
   sfp_src_e timer_src;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction : addr_hit

   assign status_write = reg_write_i && addr_hit(reg_addr_i, SFP_STATUS_ADDR);
   assign option_write = reg_write_i && addr_hit(reg_addr_i, SFP_OPTION_ADDR);
   assign timer_zero_write = reg_write_i && addr_hit(reg_addr_i, SFP_TIMER_ZERO_ADDR);
   assign owner_is_wdt = option[SFP_OP_OWNER];

   // Cause flags: power-up strap caught on every edge in reset and on the first edge after release
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_pending <= 1'b1;
      end else begin
         cause_pending <= 1'b0;
      end
   end

   // Flags survive a non-power-up reset, so only power-up loads 1/1 (see RULE_09)
   always_ff @(posedge core_clk_i) begin
      if (cause_pending && power_on_reset_i) begin
         watchdog_expiry_flag <= 1'b1;  // see RULE_01
         power_down_flag <= 1'b1;  // see RULE_02
      end else if (watchdog_timeout_i) begin
         watchdog_expiry_flag <= 1'b0;  // see RULE_08
      end else if (sleep_i || hibernate_i) begin
         watchdog_expiry_flag <= 1'b1;  // see RULE_08
         power_down_flag <= 1'b0;  // see RULE_02
      end else if (watchdog_kick_i) begin
         watchdog_expiry_flag <= 1'b1;  // see RULE_01
         power_down_flag <= 1'b1;  // see RULE_02
      end
   end

   // ALU result beats a plain write; a clear writes zero and then sets zero flag
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_null_flag <= 1'b0;
         low_nibble_overflow <= 1'b0;
         msb_overflow_flag <= 1'b0;
      end else if (alu_update_i) begin
         result_null_flag <= (alu_result_i == 8'h00);  // see RULE_03 RULE_07
         low_nibble_overflow <= alu_digit_carry_i;  // see RULE_04
         msb_overflow_flag <= alu_carry_i;  // see RULE_05
      end else if (status_write) begin
         result_null_flag <= reg_wdata_i[SFP_ST_ZERO];  // see RULE_06
         low_nibble_overflow <= reg_wdata_i[SFP_ST_DIGIT];
         msb_overflow_flag <= reg_wdata_i[SFP_ST_CARRY];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         option <= SFP_OPTION_RESET;
      end else if (option_write) begin
         option <= reg_wdata_i;  // see RULE_22
      end
   end

   assign status_o = {3'h0, watchdog_expiry_flag, power_down_flag,
                      result_null_flag, low_nibble_overflow, msb_overflow_flag};
   assign option_o = option;
   assign crystal_enable_o = option[SFP_OP_XTAL];  // see RULE_10

   always_comb begin
      case (reg_addr_i)
         SFP_STATUS_ADDR: read_mux = status_o;
         SFP_OPTION_ADDR: read_mux = option;
         default: read_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= read_mux;
      end
   end

   sfp_edge_detect u_edge (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .level_i(timer_ext_input_i),
      .sync_bypass_i(option[SFP_OP_ASYNC]),  // see RULE_11
      .falling_i(option[SFP_OP_EDGE]),  // see RULE_12
      .edge_o(ext_edge)
   );

   // Source choice for timer zero (see RULE_10)
   always_comb begin
      if (!option[SFP_OP_SRC]) begin
         timer_src = SFP_SRC_INSTR;
      end else if (option[SFP_OP_XTAL]) begin
         timer_src = SFP_SRC_XTAL;
      end else begin
         timer_src = SFP_SRC_PIN;
      end
   end

   always_comb begin
      case (timer_src)
         SFP_SRC_INSTR: timer_src_tick = instr_tick_i;
         SFP_SRC_PIN: timer_src_tick = ext_edge;
         SFP_SRC_XTAL: timer_src_tick = xtal_tick_i;
         default: timer_src_tick = 1'b0;
      endcase
   end

   // Single prescaler fed only by its owner (see RULE_13 RULE_15)
   assign presc_in_tick = owner_is_wdt ? watchdog_base_tick_i : timer_src_tick;
   assign presc_clear = (owner_is_wdt && watchdog_kick_i)  // see RULE_16
                        || (!owner_is_wdt && timer_zero_write);  // see RULE_17

   sfp_prescaler #(
      .WIDTH(SFP_PRESCALE_WIDTH)
   ) u_presc (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(presc_in_tick),
      .clear_i(presc_clear),
      .ratio_i(option[SFP_OP_PS_LO +: 3]),  // see RULE_14
      .watchdog_mode_i(owner_is_wdt),
      .count_o(),
      .out_tick_o(presc_out_tick)
   );

   // Non-owner sees its source undivided (see RULE_20 RULE_21)
   assign timer_zero_tick_o = owner_is_wdt ? timer_src_tick : presc_out_tick;
   assign watchdog_tick_o = owner_is_wdt ? presc_out_tick : watchdog_base_tick_i;
   assign watchdog_clear_o = watchdog_kick_i || sleep_i;  // see RULE_16
endmodule : sfp_status_option

// >>> test/sfp_core_model.sv
// Core-side tick source: instruction, watchdog base and crystal ticks.
// Assumes en_i changes just after a rising edge; ticks stop while low.
module sfp_core_model (
   input wire logic core_clk_i,
   input wire logic en_i,
   output logic instr_tick_o,
   output logic wdt_tick_o,
   output logic xtal_tick_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned cnt = 0;
   always @(posedge core_clk_i) begin
      cnt <= en_i ? cnt + 1 : 0;
   end
   // Instruction clock is a quarter of the core rate
   assign instr_tick_o = en_i && cnt % 4 == 3;
   // Odd periods so the sources drift apart
   assign wdt_tick_o = en_i && cnt % 5 == 4;
   assign xtal_tick_o = en_i && cnt % 3 == 2;
endmodule : sfp_core_model

// >>> test/sfp_status_option_chk.sv
// Checker bound to the status and option bank.
// Assumes cause events come as exclusive one-cycle pulses.
module sfp_status_option_chk (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_write_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic alu_update_i,
   input wire logic [7:0] alu_result_i,
   input wire logic alu_digit_carry_i,
   input wire logic alu_carry_i,
   input wire logic watchdog_kick_i,
   input wire logic sleep_i,
   input wire logic hibernate_i,
   input wire logic watchdog_timeout_i,
   input wire logic instr_tick_i,
   input wire logic watchdog_base_tick_i,
   input wire logic crystal_enable_o,
   input wire logic timer_zero_tick_o,
   input wire logic watchdog_tick_o,
   input wire logic watchdog_clear_o,
   input wire logic [7:0] status_o,
   input wire logic [7:0] option_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic live;
   wire ev = watchdog_kick_i | sleep_i | hibernate_i | watchdog_timeout_i;
   // Power-up strap owns the first edge after release
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) live <= 1'b0;
      else live <= 1'b1;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_nap;
      live && (sleep_i || hibernate_i) && !watchdog_timeout_i;
   endsequence
   sequence s_kick;
      live && watchdog_kick_i && !sleep_i && !hibernate_i && !watchdog_timeout_i;
   endsequence
   chk_nap_cause: assert property (s_nap |=> status_o[4:3] == 2'b10)
      else $error("bad flags after sleep");
   chk_kick_cause: assert property (s_kick |=> status_o[4:3] == 2'b11)
      else $error("bad flags after kick");
   chk_timeout_flag: assert property (live && watchdog_timeout_i
      |=> !status_o[4] && $stable(status_o[3])) else $error("bad flags after timeout");
   chk_alu_flags: assert property (alu_update_i |=> status_o[2:0] ==
      {$past(alu_result_i) == 8'h00, $past(alu_digit_carry_i), $past(alu_carry_i)})
      else $error("bad alu flags");
   chk_status_write: assert property (live && !ev && !alu_update_i && reg_write_i
      && reg_addr_i == 8'h03 |=> status_o == {3'h0, $past(status_o[4:3]), $past(reg_wdata_i[2:0])})
      else $error("bad status write");
   chk_option_write: assert property (reg_write_i && reg_addr_i == 8'h07
      |=> option_o == $past(reg_wdata_i) && crystal_enable_o == option_o[7])
      else $error("bad option write");
   chk_wdt_direct: assert property (!option_o[3]
      |-> watchdog_tick_o == watchdog_base_tick_i) else $error("watchdog tick divided");
   chk_timer_direct: assert property (option_o[3] && !option_o[5]
      |-> timer_zero_tick_o == instr_tick_i) else $error("timer tick divided");
   chk_kick_clear: assert property (watchdog_kick_i |-> watchdog_clear_o)
      else $error("kick did not clear watchdog");
endmodule : sfp_status_option_chk
bind sfp_status_option sfp_status_option_chk chk (.*);

// >>> test/sfp_status_option_tb.sv
// Self-checking bench for the status flag and option bank.
// Assumes the checker binds itself; the core model supplies ticks.
module sfp_status_option_tb
   import sfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, por = 1, wr = 0, alu = 0, dc = 0, cy = 0, pin = 0, en = 0;
   logic ti, wi, xi, xe, to, wo, wc;
   logic [3:0] evt = 4'h0;
   logic [7:0] addr = 8'h00, wd = 8'h00, res = 8'h00, rd, st, op;
   int err_count = 0, n_compared = 0, n_ti = 0, n_wi = 0, n_xi = 0, n_to = 0, n_wo = 0;
   sfp_status_option dut (.core_clk_i(clk), .rst_n_i(rst_n), .power_on_reset_i(por),
      .reg_addr_i(addr), .reg_write_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rd),
      .alu_update_i(alu), .alu_result_i(res), .alu_digit_carry_i(dc), .alu_carry_i(cy),
      .watchdog_kick_i(evt[0]), .sleep_i(evt[1]), .hibernate_i(evt[2]),
      .watchdog_timeout_i(evt[3]), .instr_tick_i(ti), .watchdog_base_tick_i(wi),
      .timer_ext_input_i(pin), .xtal_tick_i(xi), .crystal_enable_o(xe),
      .timer_zero_tick_o(to), .watchdog_tick_o(wo), .watchdog_clear_o(wc), .status_o(st),
      .option_o(op));
   sfp_core_model core (.core_clk_i(clk), .en_i(en), .instr_tick_o(ti), .wdt_tick_o(wi),
      .xtal_tick_o(xi));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      n_ti <= en ? n_ti + ti : 0;
      n_wi <= en ? n_wi + wi : 0;
      n_xi <= en ? n_xi + xi : 0;
      n_to <= en ? n_to + to : 0;
      n_wo <= en ? n_wo + wo : 0;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   task automatic do_reset(input logic p);
      rst_n <= 1'b0;
      por <= p;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset
   task automatic wr_reg(input logic [7:0] a, d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic ev(input logic [3:0] m, input logic [1:0] exp);
      evt <= m;
      @(posedge clk);
      check("watchdog clear", wc, m[0] | m[1]);
      evt <= 4'h0;
      @(posedge clk);
      check("cause flags", st[4:3], exp);
   endtask : ev
   task automatic rd_chk(input string what, input logic [7:0] a, exp);
      addr <= a;
      repeat (2) @(posedge clk);
      check(what, rd, exp);
   endtask : rd_chk
   task automatic t_regs;
      check("option", op, SFP_OPTION_RESET);
      rd_chk("status read", SFP_STATUS_ADDR, 8'h18);
      rd_chk("option read", SFP_OPTION_ADDR, SFP_OPTION_RESET);
      rd_chk("unmapped read", 8'h05, 8'h00);
      $display("register test done");
   endtask : t_regs
   task automatic t_alu;
      for (int i = 0; i < 4; i++) begin
         res <= i[0] ? 8'h5A : 8'h00;
         dc <= i[1];
         cy <= i[0] ^ i[1];
         alu <= 1'b1;
         @(posedge clk);
         alu <= 1'b0;
         @(posedge clk);
         check("alu flags", st[2:0], {!i[0], i[1], i[0] ^ i[1]});
      end
      $display("alu test done");
   endtask : t_alu
   task automatic t_clear;
      wr_reg(SFP_STATUS_ADDR, 8'hFF);
      check("status write", st, 8'h1F);
      wd <= 8'h00;
      res <= 8'h00;
      dc <= 1'b0;
      wr <= 1'b1;
      alu <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      alu <= 1'b0;
      @(posedge clk);
      check("status clear", st, 8'h1C);
      $display("clear test done");
   endtask : t_clear
   task automatic t_events;
      ev(4'h2, 2'b10);
      ev(4'h8, 2'b00);
      ev(4'h1, 2'b11);
      ev(4'h8, 2'b01);
      do_reset(1'b0);
      check("cause kept", st[4:3], 2'b01);
      ev(4'h4, 2'b10);
      $display("event test done");
   endtask : t_events
   task automatic t_ratio(input logic own, input logic [2:0] r);
      if (own) begin
         wr_reg(SFP_TIMER_ZERO_ADDR, 8'h00);
         ev(4'h1, 2'b11);
         wr_reg(SFP_OPTION_ADDR, 8'h0F);
      end else begin
         ev(4'h1, 2'b11);
      end
      wr_reg(SFP_OPTION_ADDR, {4'h0, own, r});
      if (!own) wr_reg(SFP_TIMER_ZERO_ADDR, 8'h00);
      en <= 1'b1;
      // One tick short of the largest ratio period, so a missed prescaler clear shows up
      for (int k = 0; k < 5000 && (own ? n_wi != 127 : n_ti != 255); k++) @(posedge clk);
      if (own) begin
         check("wdt ticks", n_wo, (128 >> r) - 1);
         check("timer ticks", n_to, n_ti);
      end else begin
         check("timer ticks", n_to, (256 >> (r + 1)) - 1);
         check("wdt ticks", n_wo, n_wi);
      end
      en <= 1'b0;
      @(posedge clk);
      $display("ratio test done owner %0d code %0d", own, r);
   endtask : t_ratio
   task automatic t_src;
      for (int i = 0; i < 4; i++) begin
         wr_reg(SFP_OPTION_ADDR, {1'b0, i[1], 1'b1, i[0], 4'h8});
         en <= 1'b1;
         pin <= 1'b1;
         repeat (8) @(posedge clk);
         check("rise edge", n_to, !i[0]);
         pin <= 1'b0;
         repeat (8) @(posedge clk);
         check("fall edge", n_to, 1);
         en <= 1'b0;
      end
      wr_reg(SFP_OPTION_ADDR, 8'hA8);
      en <= 1'b1;
      repeat (30) @(posedge clk);
      check("crystal enable", xe, 1'b1);
      check("crystal ticks", n_to, n_xi);
      en <= 1'b0;
      $display("source test done");
   endtask : t_src
   initial begin
      do_reset(1'b1);
      t_regs;
      t_alu;
      t_clear;
      t_events;
      for (int r = 0; r < 16; r++) t_ratio(r[3], r[2:0]);
      t_src;
      complete_run;
   end
   // Runs near 13.5k cycles; allow well over double
   initial begin
      #1000000;
      err_count++;
      complete_run;
   end
endmodule : sfp_status_option_tb
